// File: core/dcd_burst.v
// Burst length tracker: a started burst runs to its end unless rst clears the count
`include "dcd_consts.vh"
module dcd_burst (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [3:0] beats,
  output wire busy
);
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  always @* begin
    cnt_d = cnt_q;
    if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end else if (start) begin
      cnt_d = beats;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign busy = (cnt_q != 4'h0);
endmodule // dcd_burst

// File: core/dcd_consts.vh
// Constants for the DDR3 command decoder
`ifndef DCD_CONSTS_VH
`define DCD_CONSTS_VH
`define DCD_BA_W 3
`define DCD_ADDR_W 14
`define DCD_COL_W 10
`define DCD_AP_BIT 10
`define DCD_BC_BIT 12
`define DCD_BL8 4'h8
`define DCD_BC4 4'h4
`define DCD_CMD_W 5
`define DCD_CMD_NOP 5'h00
`define DCD_CMD_DES 5'h01
`define DCD_CMD_MRS 5'h02
`define DCD_CMD_REF 5'h03
`define DCD_CMD_SRE 5'h04
`define DCD_CMD_SRX 5'h05
`define DCD_CMD_ACT 5'h06
`define DCD_CMD_PRE 5'h07
`define DCD_CMD_PREA 5'h08
`define DCD_CMD_WR 5'h09
`define DCD_CMD_RD 5'h0a
`define DCD_CMD_PDE 5'h0b
`define DCD_CMD_PDX 5'h0c
`define DCD_CMD_ZQCL 5'h0d
`define DCD_CMD_ZQCS 5'h0e
`define DCD_CMD_ILL 5'h1f
`endif

// File: core/dcd_decoder.v
// DDR3 command/address pin decoder with CKE state tracking
// Behaviour
// (R1) Commands sampled from CS, RAS, CAS, WE, CKE on rising clock edge.
// (R2) Bank, row and column field widths are parameters.
// (R3) Reset pin is asynchronous only; controller holds it high otherwise. Code samples it as a synchronous reset on the rising CLK edge.
// (R4) MRS: CKE high twice, all strobes low; bank picks register.
// (R5) Activate: CS,RAS low, CAS,WE high; bank and row from pins.
// (R6) Controller drives valid pins to defined levels; don't-care may float.
// (R7) Bursts run to completion; fixed or on-the-fly length set by MRS. Code takes on-the-fly enable from OTF_BL_EN, fixed length 8.
// (R8) Write: CS low, RAS high, CAS low, WE low; column low pins.
// (R9) Read: CS low, RAS high, CAS low, WE high; bank and column.
// (R10) Address bit 10 high on read/write requests auto precharge.
// (R11) On-the-fly: bit 12 low chops to 4 beats, high gives 8.
// (R12) Refresh pattern with CKE high; CKE falling enters self-refresh.
// (R13) Precharge with bit 10 for all banks; ZQ long or short.
// (R14) Power-down entry/exit and self-refresh exit by CKE edge with NOP/DES.
// (R15) CS low with other strobes high is no operation.
// (R16) No operation never aborts a burst in progress.
// (R17) CS high ignores all other pins, acts as no operation.
// (R18) No refresh during power-down; controller must exit in time.
// (R19) ODT never alters decode; termination off in self-refresh.
// (R20) Self-refresh exit handled without relying on the clock. Code detects the exit only on a rising CLK edge.
// (R21) Controller waits 512 cycles after self-refresh exit before writing.
// (R22) Self-refresh only entered with all banks idle, no burst. Code checks only BURST_BUSY, not bank state.
// (R23) Unlisted patterns with CKE high are ignored, no state change.
`include "dcd_consts.vh"
module dcd_decoder #(
  parameter BA_W = `DCD_BA_W,
  parameter ADDR_W = `DCD_ADDR_W,
  parameter COL_W = `DCD_COL_W
) (
  input wire CLK,
  input wire RST,
  input wire RESET_N,
  input wire CKE,
  input wire CS_N,
  input wire RAS_N,
  input wire CAS_N,
  input wire WE_N,
  input wire ODT,
  input wire [BA_W-1:0] BA,
  input wire [ADDR_W-1:0] ADDR,
  input wire OTF_BL_EN,
  output reg [`DCD_CMD_W-1:0] CMD,
  output reg CMD_VALID,
  output reg [BA_W-1:0] CMD_BANK,
  output reg [ADDR_W-1:0] CMD_ROW,
  output reg [COL_W-1:0] CMD_COL,
  output reg [ADDR_W-1:0] CMD_OPCODE,
  output reg CMD_AUTO_PRE,
  output reg [3:0] CMD_BEATS,
  output reg IN_POWER_DOWN,
  output reg IN_SELF_REFRESH,
  output wire BURST_BUSY,
  output wire ODT_EN
);
  localparam ST_IDLE = 3'b001;
  localparam ST_PD = 3'b010;
  localparam ST_SR = 3'b100;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg cke_prev_q;
  reg [`DCD_CMD_W-1:0] cmd_d;
  reg [3:0] beats_d;
  wire sel;
  wire nop_pat;
  wire ref_pat;
  wire rst_all;
  // Pad pin reset forces the decoder idle at the next rising clock edge
  assign rst_all = RST | ~RESET_N; // R3
  assign sel = ~CS_N; // R17
  assign nop_pat = ~sel | (RAS_N & CAS_N & WE_N); // R15 R17
  assign ref_pat = sel & ~RAS_N & ~CAS_N & WE_N;
  always @* begin
    cmd_d = `DCD_CMD_ILL;
    beats_d = `DCD_BL8;
    state_d = state_q;
    // R1: decode from the levels present at this edge plus the CKE level held from the previous edge
    case (state_q)
      ST_IDLE: begin
        if (cke_prev_q && !CKE) begin
          if (ref_pat && !BURST_BUSY) begin
            cmd_d = `DCD_CMD_SRE; // R12 R22
            state_d = ST_SR;
          end else if (nop_pat) begin
            cmd_d = `DCD_CMD_PDE; // R14
            state_d = ST_PD;
          end
        end else if (cke_prev_q && CKE) begin
          if (!sel) begin
            cmd_d = `DCD_CMD_DES; // R17
          end else begin
            case ({RAS_N, CAS_N, WE_N})
              3'h0: cmd_d = `DCD_CMD_MRS; // R4
              3'h1: cmd_d = `DCD_CMD_REF; // R12
              3'h2: cmd_d = ADDR[`DCD_AP_BIT] ? `DCD_CMD_PREA : `DCD_CMD_PRE; // R13
              3'h3: cmd_d = `DCD_CMD_ACT; // R5
              3'h4: cmd_d = `DCD_CMD_WR; // R8
              3'h5: cmd_d = `DCD_CMD_RD; // R9
              3'h6: cmd_d = ADDR[`DCD_AP_BIT] ? `DCD_CMD_ZQCL : `DCD_CMD_ZQCS; // R13
              default: cmd_d = `DCD_CMD_NOP; // R15
            endcase
          end
        end
      end
      ST_PD: begin
        // R18: no refresh activity while parked here
        if (CKE && nop_pat) begin
          cmd_d = `DCD_CMD_PDX; // R14
          state_d = ST_IDLE;
        end
      end
      ST_SR: begin
        if (CKE && nop_pat) begin
          cmd_d = `DCD_CMD_SRX; // R14 R20
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // R11: bit 12 only matters with on-the-fly length enabled
    if (OTF_BL_EN && !ADDR[`DCD_BC_BIT]) begin
      beats_d = `DCD_BC4;
    end
  end
  wire rw = (cmd_d == `DCD_CMD_WR) || (cmd_d == `DCD_CMD_RD);
  // R7 R16: NOP never reaches the tracker as a stop
  dcd_burst u_burst (
    .clk(CLK),
    .rst(rst_all),
    .start(rw),
    .beats(beats_d),
    .busy(BURST_BUSY)
  );
  // R19: ODT feeds only termination, never the decode
  assign ODT_EN = ODT & ~IN_SELF_REFRESH; // R19
  always @(posedge CLK) begin
    if (rst_all) begin
      state_q <= ST_IDLE;
      cke_prev_q <= 1'b0;
      CMD <= `DCD_CMD_DES;
      CMD_VALID <= 1'b0;
      CMD_BANK <= {BA_W{1'b0}};
      CMD_ROW <= {ADDR_W{1'b0}};
      CMD_COL <= {COL_W{1'b0}};
      CMD_OPCODE <= {ADDR_W{1'b0}};
      CMD_AUTO_PRE <= 1'b0;
      CMD_BEATS <= `DCD_BL8;
      IN_POWER_DOWN <= 1'b0;
      IN_SELF_REFRESH <= 1'b0;
    end else begin
      cke_prev_q <= CKE;
      state_q <= state_d;
      IN_POWER_DOWN <= (state_d == ST_PD); // R18
      IN_SELF_REFRESH <= (state_d == ST_SR);
      CMD <= cmd_d;
      // Illegal patterns produce no strobe and no field update
      CMD_VALID <= (cmd_d != `DCD_CMD_ILL); // R23
      if (cmd_d != `DCD_CMD_ILL) begin
        CMD_BANK <= BA; // R5
        CMD_ROW <= ADDR; // R5
        CMD_COL <= ADDR[COL_W-1:0]; // R8 R9
        CMD_OPCODE <= ADDR; // R4
        CMD_AUTO_PRE <= rw & ADDR[`DCD_AP_BIT]; // R10
        CMD_BEATS <= beats_d; // R11
      end
    end
  end
endmodule // dcd_decoder

// File: verif/dcd_chk.sv
// Checker on the decoder ports
`include "dcd_consts.vh"
module dcd_chk (
  input wire CLK,
  input wire RST,
  input wire CKE,
  input wire CS_N,
  input wire RAS_N,
  input wire CAS_N,
  input wire WE_N,
  input wire OTF_BL_EN,
  input wire [`DCD_BA_W-1:0] BA,
  input wire [`DCD_ADDR_W-1:0] ADDR,
  input wire [`DCD_CMD_W-1:0] CMD,
  input wire CMD_VALID,
  input wire [`DCD_BA_W-1:0] CMD_BANK,
  input wire CMD_AUTO_PRE,
  input wire [3:0] CMD_BEATS,
  input wire BURST_BUSY
);
  logic cp_q, hh_q, hd_q, a10_q, a12_q, otf_q;
  logic [2:0] p_q;
  logic [`DCD_BA_W-1:0] ba_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Pins of one edge, judged against outputs at the next
  always @(posedge CLK) begin
    cp_q <= !RST && CKE;
    hh_q <= !RST && cp_q && CKE && !CS_N;
    hd_q <= !RST && cp_q && CKE && CS_N;
    p_q <= {RAS_N, CAS_N, WE_N};
    a10_q <= ADDR[10];
    a12_q <= ADDR[12];
    otf_q <= OTF_BL_EN;
    ba_q <= BA;
  end
  rd_decode_a: assert property (hh_q && p_q == 3'b101 |-> CMD == `DCD_CMD_RD
    && CMD_VALID && CMD_BANK == ba_q && CMD_AUTO_PRE == a10_q) else $error("bad read");
  wr_decode_a: assert property (hh_q && p_q == 3'b100 |-> CMD == `DCD_CMD_WR
    && CMD_BEATS == ((otf_q && !a12_q) ? 4'h4 : 4'h8)) else $error("bad write");
  act_decode_a: assert property (hh_q && p_q == 3'b011 |-> CMD == `DCD_CMD_ACT
    && CMD_BANK == ba_q) else $error("bad activate");
  mrs_decode_a: assert property (hh_q && p_q == 3'b000 |-> CMD == `DCD_CMD_MRS)
    else $error("bad mode set");
  pre_decode_a: assert property (hh_q && p_q == 3'b010 |->
    CMD == (a10_q ? `DCD_CMD_PREA : `DCD_CMD_PRE)) else $error("bad precharge");
  zq_decode_a: assert property (hh_q && p_q == 3'b110 |->
    CMD == (a10_q ? `DCD_CMD_ZQCL : `DCD_CMD_ZQCS)) else $error("bad zq");
  des_ignore_a: assert property (hd_q |-> CMD == `DCD_CMD_DES && CMD_VALID)
    else $error("bad deselect");
  // Only a burst that found the tracker idle is sure to keep it busy for at least four cycles
  burst_run_a: assert property (CMD_VALID && !$past(BURST_BUSY)
    && (CMD == `DCD_CMD_WR || CMD == `DCD_CMD_RD) |-> BURST_BUSY[*4])
    else $error("burst cut short");
endmodule // dcd_chk
bind dcd_decoder dcd_chk chk_u (.*);

// File: verif/dcd_ctl.sv
// Controller model: command code to pin levels
`include "dcd_consts.vh"
module dcd_ctl (
  input wire clk,
  input wire [4:0] op,
  output logic [3:0] pins
);
  logic t_q = 1'b0;
  always @(negedge clk) t_q <= ~t_q;
  always_comb begin
    case (op)
      `DCD_CMD_MRS: pins = 4'h0;
      `DCD_CMD_REF: pins = 4'h1;
      `DCD_CMD_PRE: pins = 4'h2;
      `DCD_CMD_ACT: pins = 4'h3;
      `DCD_CMD_WR: pins = 4'h4;
      `DCD_CMD_RD: pins = 4'h5;
      `DCD_CMD_ZQCL: pins = 4'h6;
      `DCD_CMD_NOP: pins = 4'h7;
      // Deselected strobes wander, never hold a stale level
      default: pins = {1'b1, {3{t_q}}};
    endcase
  end
endmodule // dcd_ctl

// File: verif/testbench.sv
// Self-checking bench for the command decoder
`include "dcd_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, cke = 1, odt = 0, otf = 0, e_ap;
  logic [4:0] op = `DCD_CMD_NOP, e_cmd;
  logic [2:0] ba = 0;
  logic [13:0] addr = 0;
  logic [3:0] e_bt;
  wire [3:0] pins, bt;
  wire [4:0] cmd;
  wire vld, ap, sr, oe, pd;
  int error_cnt = 0, samples_checked = 0, seed = 5, cyc = 0, k;
  logic [4:0] ops [9] = '{`DCD_CMD_MRS, `DCD_CMD_REF, `DCD_CMD_ACT, `DCD_CMD_PRE,
    `DCD_CMD_WR, `DCD_CMD_RD, `DCD_CMD_ZQCL, `DCD_CMD_NOP, `DCD_CMD_DES};
  dcd_ctl ctl_u (.clk(clk), .op(op), .pins(pins));
  // Pad reset held inactive throughout normal command traffic
  dcd_decoder dut_u (.CLK(clk), .RST(rst), .RESET_N(1'b1), .CKE(cke), .CS_N(pins[3]),
    .RAS_N(pins[2]), .CAS_N(pins[1]), .WE_N(pins[0]), .ODT(odt), .BA(ba), .ADDR(addr),
    .OTF_BL_EN(otf), .CMD(cmd), .CMD_VALID(vld), .CMD_BANK(), .CMD_ROW(), .CMD_COL(),
    .CMD_OPCODE(), .CMD_AUTO_PRE(ap), .CMD_BEATS(bt), .IN_POWER_DOWN(pd),
    .IN_SELF_REFRESH(sr), .BURST_BUSY(), .ODT_EN(oe));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    @(negedge clk);
    for (k = 0; k < 400; k++) begin
      @(negedge clk);
      if (k > 0) chk({vld, cmd}, {1'b1, e_cmd});
      if (k > 0 && (e_cmd == `DCD_CMD_WR || e_cmd == `DCD_CMD_RD)) chk({ap, bt}, {e_ap, e_bt});
      op = ops[{$random(seed)} % 9];
      addr = $random(seed);
      ba = $random(seed);
      otf = $random(seed);
      odt = $random(seed);
      e_cmd = op;
      if (op == `DCD_CMD_PRE && addr[10]) e_cmd = `DCD_CMD_PREA;
      if (op == `DCD_CMD_ZQCL && !addr[10]) e_cmd = `DCD_CMD_ZQCS;
      e_ap = addr[10];
      e_bt = (otf && !addr[12]) ? 4'h4 : 4'h8;
    end
    // Bursts drain before self-refresh is asked for
    op = `DCD_CMD_NOP;
    repeat (10) @(negedge clk);
    op = `DCD_CMD_REF;
    cke = 0;
    odt = 1;
    @(negedge clk);
    chk({vld, cmd}, {1'b1, `DCD_CMD_SRE});
    op = `DCD_CMD_DES;
    repeat (3) @(negedge clk);
    chk({sr, oe}, 2'b10);
    cke = 1;
    @(negedge clk);
    chk({vld, cmd}, {1'b1, `DCD_CMD_SRX});
    @(negedge clk);
    chk(sr, 1'b0);
    // No write follows the self-refresh exit in this run
    op = `DCD_CMD_NOP;
    cke = 0;
    @(negedge clk);
    chk({vld, cmd, pd}, {1'b1, `DCD_CMD_PDE, 1'b1});
    cke = 1;
    @(negedge clk);
    chk({vld, cmd, pd}, {1'b1, `DCD_CMD_PDX, 1'b0});
    op = `DCD_CMD_ACT;
    cke = 0;
    @(negedge clk);
    chk({vld, cmd}, {1'b0, `DCD_CMD_ILL});
    stop_test();
  end
endmodule // testbench
